// *** core/irq_prio_pkg.sv ***
// Package of offsets, field layout and reset values for the priority store.
// Assumes a 32-bit AXI4-Lite register bus, byte addresses relative to the
// system control space base.
//
// Contract
// - Four 2-bit fields at bits 7,15,23,31
// - Zero most urgent, three least urgent
// - Lines 12..15 at 0x40C, stepping four bytes
// - All priority registers reset to zero
// - Every field writable and read back
// - Offset 0x414 holds lines 20 to 23
// - Lines 0..11 from 0x400, same layout
`default_nettype none
package irq_prio_pkg;

  // Bus widths
  localparam int ADDR_WIDTH = 12;
  localparam int DATA_WIDTH = 32;

  // Offsets of the priority array
  localparam logic [11:0] PRIO_ARRAY_BASE  = 12'h400;
  localparam logic [11:0] PRIO_LINES_12_15 = 12'h40c;
  localparam logic [11:0] PRIO_LINES_16_19 = 12'h410;
  localparam logic [11:0] PRIO_LINES_20_23 = 12'h414;
  localparam logic [11:0] PRIO_LINES_24_27 = 12'h418;
  localparam logic [11:0] PRIO_LINES_28_31 = 12'h41c;

  // Range held by this block
  localparam int FIRST_LINE = 12;
  localparam int LINE_COUNT = 20;
  localparam int REG_COUNT  = 5;
  localparam int FIELDS_PER_REG = 4;

  // Field layout: each byte keeps its priority in its top two bits
  localparam int PRIO_WIDTH  = 2;
  localparam int FIELD_SHIFT = 6;
  localparam int FIELD_STEP  = 8;

  // Priority levels
  localparam logic [1:0] PRIO_MOST_URGENT  = 2'h0;
  localparam logic [1:0] PRIO_LEAST_URGENT = 2'h3;

  // Reset value of every priority register
  localparam logic [31:0] PRIO_RESET = 32'h0000_0000;
  localparam logic [31:0] READ_ZERO  = 32'h0000_0000;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : irq_prio_pkg
`default_nettype wire

// *** core/irq_prio_regs.sv ***
// AXI4-Lite slave holding interrupt priorities for lines 12 to 31.
// Assumes addresses relative to the system control space base; the
// arbiter consuming line_priority sits outside and treats 0 as urgent.
`timescale 1ns/1ps
`default_nettype none
module irq_prio_regs
  import irq_prio_pkg::*;
(
  input  wire logic                         clock,
  input  wire logic                         reset,
  input  wire logic [ADDR_WIDTH-1:0]        s_axi_awaddr,
  input  wire logic [2:0]                   s_axi_awprot,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [DATA_WIDTH-1:0]        s_axi_wdata,
  input  wire logic [DATA_WIDTH/8-1:0]      s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [ADDR_WIDTH-1:0]        s_axi_araddr,
  input  wire logic [2:0]                   s_axi_arprot,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [DATA_WIDTH-1:0]             s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  output logic [LINE_COUNT*PRIO_WIDTH-1:0]  line_priority
);

  prio_store_if store_bus ();

  // Captured write address and data
  logic                  aw_held_q;
  logic [ADDR_WIDTH-1:0] aw_addr_q;
  logic                  w_held_q;
  logic [DATA_WIDTH-1:0] w_data_q;
  logic [3:0]            w_strb_q;

  // Address decode results
  logic       wr_hit;
  logic [2:0] wr_idx;
  logic       rd_hit;
  logic [2:0] rd_idx;

  // First register of this block, reckoned from the start of the array;
  // lines 0..11 occupy the three words below it with the same layout
  localparam logic [ADDR_WIDTH-1:0] FIRST_REG_OFFSET =
    PRIO_ARRAY_BASE + ADDR_WIDTH'(FIRST_LINE / FIELDS_PER_REG * 4);

  // Map an offset to a register index; lines 0..11 live elsewhere
  // Index 8 flags a miss, so the top bit alone tells hit from miss
  function automatic logic [3:0] decode(input logic [ADDR_WIDTH-1:0] a);
    logic [3:0] r;
    r = 4'h8;
    if (a == FIRST_REG_OFFSET) begin
      r = 4'h0;
    end else if (a == PRIO_LINES_16_19) begin
      r = 4'h1;
    end else if (a == PRIO_LINES_20_23) begin
      r = 4'h2;
    end else if (a == PRIO_LINES_24_27) begin
      r = 4'h3;
    end else if (a == PRIO_LINES_28_31) begin
      r = 4'h4;
    end
    return r;
  endfunction : decode

  logic [3:0] wr_dec;
  logic [3:0] rd_dec;
  assign wr_dec = decode(aw_addr_q);
  assign rd_dec = decode(s_axi_araddr);
  assign wr_hit = !wr_dec[3];
  assign wr_idx = wr_dec[2:0];
  assign rd_hit = !rd_dec[3];
  assign rd_idx = rd_dec[2:0];

  // Ready while nothing held and no response pending
  // Write timing, counted from the edge that takes the later channel:
  //   edge 0  address and data held
  //   cycle 1 merge and commit into the store
  //   edge 1  store updated, response raised
  //   edge 2+ response stands until bready is seen high
  // Holding both channels first lets them arrive in either order,
  // at the cost of one cycle of latency per write.
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_q && !s_axi_bvalid;

  // Write address capture
  always_ff @(posedge clock) begin
    if (reset) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (aw_held_q && w_held_q) begin
      aw_held_q <= 1'b0;
    end
  end

  // Write data capture
  always_ff @(posedge clock) begin
    if (reset) begin
      w_held_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (aw_held_q && w_held_q) begin
      w_held_q <= 1'b0;
    end
  end

  // Each field sits in its own byte lane, so lanes merge per byte
  logic [DATA_WIDTH-1:0] merged;
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      merged[b*8 +: 8] = w_strb_q[b] ? w_data_q[b*8 +: 8]
                                     : store_bus.rd_data[b*8 +: 8];
    end
  end

  // Store port: read side shares the index during a write merge
  logic do_write;
  assign do_write          = aw_held_q && w_held_q;
  // Address read is refused while a write commits: the store's read
  // port is lent to the merge then, and a taken address would be lost
  assign s_axi_arready     = !s_axi_rvalid && !do_write;
  assign store_bus.wr_en   = do_write && wr_hit;
  assign store_bus.wr_sel  = wr_idx;
  assign store_bus.wr_data = merged;
  assign store_bus.rd_sel  = do_write ? wr_idx : rd_idx;

  // Write response; unmapped offsets answer SLVERR
  always_ff @(posedge clock) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read response; a pending write merge holds off reads one cycle
  logic rd_take;
  assign rd_take = s_axi_arvalid && s_axi_arready && !do_write;
  always_ff @(posedge clock) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= READ_ZERO;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_hit ? store_bus.rd_data : READ_ZERO;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Storage; the arbiter reads 0 as most urgent, 3 as least
  prio_store u_store (
    .clock         (clock),
    .reset         (reset),
    .bus           (store_bus.store),
    .line_priority (line_priority)
  );

endmodule : irq_prio_regs
`default_nettype wire

// *** core/prio_store.sv ***
// Priority storage for lines 12 to 31, one 2-bit field per line.
// Assumes the bus slave has already decoded the register index.
`timescale 1ns/1ps
`default_nettype none
module prio_store
  import irq_prio_pkg::*;
(
  input  wire logic                         clock,
  input  wire logic                         reset,
  prio_store_if.store                       bus,
  output logic [LINE_COUNT*PRIO_WIDTH-1:0]  line_priority
);

  // One field per line; index 0 is line 12
  logic [PRIO_WIDTH-1:0] prio_q [LINE_COUNT];

  // Per-line storage, reset to most urgent
  for (genvar i = 0; i < LINE_COUNT; i++) begin : g_line
    localparam int REG_IDX = i / FIELDS_PER_REG;
    localparam int LSB = (i % FIELDS_PER_REG) * FIELD_STEP + FIELD_SHIFT;
    always_ff @(posedge clock) begin
      if (reset) begin
        prio_q[i] <= PRIO_MOST_URGENT;
      end else if (bus.wr_en && bus.wr_sel == 3'(REG_IDX)) begin
        // Only field bits are taken, reserved bits drop away
        prio_q[i] <= bus.wr_data[LSB +: PRIO_WIDTH];
      end
    end
    assign line_priority[i*PRIO_WIDTH +: PRIO_WIDTH] = prio_q[i];
  end

  // Read packing; reserved bits stay zero
  always_comb begin
    bus.rd_data = READ_ZERO;
    for (int f = 0; f < FIELDS_PER_REG; f++) begin
      if (int'(bus.rd_sel) < REG_COUNT) begin
        bus.rd_data[f*FIELD_STEP+FIELD_SHIFT +: PRIO_WIDTH] =
          prio_q[int'(bus.rd_sel)*FIELDS_PER_REG + f];
      end
    end
  end

endmodule : prio_store
`default_nettype wire

// *** core/prio_store_if.sv ***
// Interface between bus slave and priority storage.
// Assumes one clock; write and read decode are done in the slave.
`timescale 1ns/1ps
`default_nettype none
interface prio_store_if;
  import irq_prio_pkg::*;
  logic                  wr_en;   // One-cycle write strobe
  logic [2:0]            wr_sel;  // Register index 0..4
  logic [DATA_WIDTH-1:0] wr_data; // Strobe-merged write word
  logic [2:0]            rd_sel;  // Register index for read
  logic [DATA_WIDTH-1:0] rd_data; // Packed read word
  modport slave (output wr_en, wr_sel, wr_data, rd_sel, input rd_data);
  modport store (input wr_en, wr_sel, wr_data, rd_sel, output rd_data);
endinterface : prio_store_if
`default_nettype wire

// *** sim/irq_prio_regs_asserts.sv ***
// Checker for the priority register slave.
// Assumes it is bound onto the slave's ports and one clock.
`timescale 1ns/1ps
`default_nettype none
module irq_prio_asserts
  import irq_prio_pkg::*;
(
  input wire logic                 clock,
  input wire logic                 reset,
  input wire logic                 s_axi_awready,
  input wire logic                 s_axi_wready,
  input wire logic                 s_axi_bvalid,
  input wire logic                 s_axi_bready,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic                 s_axi_rvalid,
  input wire logic                 s_axi_rready,
  input wire logic [DATA_WIDTH-1:0] s_axi_rdata,
  input wire logic [LINE_COUNT*PRIO_WIDTH-1:0] line_priority
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // Reserved bits never show on a read
  AST_RSV_ZERO: assert property (s_axi_rvalid |->
    (s_axi_rdata & 32'h3f3f_3f3f) == 32'h0000_0000) else $error("rsv bits");
  // Store leaves reset cleared
  AST_RST_CLEAR: assert property ($past(reset) |->
    line_priority == '0) else $error("not cleared");
  // Fields move only with a write response
  AST_PRIO_CHG: assert property ($changed(line_priority) |->
    $rose(s_axi_bvalid)) else $error("field moved");
  AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("no read answer");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
  AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid) else $error("read stuck");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid) else $error("write resp dropped");
  AST_AW_BLOCK: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken early");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken early");
  // Main scenarios
  COV_WR: cover property (s_axi_bvalid && s_axi_bready);
  COV_RD: cover property (s_axi_rvalid && s_axi_rready);
  COV_LEAST: cover property (line_priority[1:0] == PRIO_LEAST_URGENT);
  COV_B_STALL: cover property (s_axi_bvalid && !s_axi_bready);
endmodule : irq_prio_asserts
`default_nettype wire

// *** sim/testbench.sv ***
// Self-checking bench for the priority register slave.
// Assumes the core package, interface and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import irq_prio_pkg::*;
  logic clock, reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [39:0] line_priority;
  int error_cnt, checked;
  irq_prio_regs irq_prio_regs_i (.*);
  // 100 ns period
  always #50 clock = ~clock;
  // Shared compare
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Write; both channels offered together, each dropped when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    logic ta, tw, na, nw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ta && tw)) begin
      // Ready is settled mid-cycle
      @(negedge clock);
      na = !ta && s_axi_awready;
      nw = !tw && s_axi_wready;
      @(posedge clock);
      if (na) s_axi_awvalid <= 1'b0;
      if (nw) s_axi_wvalid <= 1'b0;
      ta = ta || na;
      tw = tw || nw;
    end
    do @(negedge clock); while (!s_axi_bvalid);
    chk(40'(s_axi_bresp), 40'(er));
    @(posedge clock);
    s_axi_bready <= 1'b0;
  endtask : wr
  // Read and compare data and response
  task automatic rd(input logic [11:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge clock); while (!s_axi_arready);
    @(posedge clock);
    s_axi_arvalid <= 1'b0;
    do @(negedge clock); while (!s_axi_rvalid);
    chk(40'(s_axi_rdata), 40'(ed));
    chk(40'(s_axi_rresp), 40'(er));
    @(posedge clock);
    s_axi_rready <= 1'b0;
  endtask : rd
  // All five registers: reset value, full write, reserved bits dropped
  task automatic t_fields;
    for (int i = 0; i < 5; i++) rd(PRIO_LINES_12_15 + 12'(4*i), 0, 0);
    chk(line_priority, 40'h00_0000_0000);
    for (int i = 0; i < 5; i++) begin
      wr(PRIO_LINES_12_15 + 12'(4*i), 32'hffff_ffff, 4'hf, 0);
      rd(PRIO_LINES_12_15 + 12'(4*i), 32'hc0c0_c0c0, 0);
    end
    chk(line_priority, 40'hff_ffff_ffff);
    wr(PRIO_LINES_20_23, 32'h4080_00c0, 4'hf, 0);
    rd(PRIO_LINES_20_23, 32'h4080_00c0, 0);
    chk(line_priority, 40'hff_ff63_ffff);
    $display("fields test done");
  endtask : t_fields
  // Byte strobe, unmapped offsets, second reset
  task automatic t_edges;
    wr(PRIO_LINES_12_15, 32'h0000_0000, 4'h2, 0);
    rd(PRIO_LINES_12_15, 32'hc0c0_00c0, 0);
    wr(12'h408, 32'hffff_ffff, 4'hf, 2);
    rd(12'h408, 0, 2);
    rd(12'h420, 0, 2);
    chk(line_priority, 40'hff_ff63_fff3);
    @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    chk(line_priority, 40'h00_0000_0000);
    rd(PRIO_LINES_28_31, 0, 0);
    $display("edges test done");
  endtask : t_edges
  // Read offered during a write commit, then stalled answers
  task automatic t_stall;
    fork
      wr(PRIO_LINES_16_19, 32'h0000_0080, 4'hf, 0);
      begin
        @(posedge clock);
        rd(PRIO_LINES_16_19, 32'h0000_0080, 0);
      end
    join
    chk(line_priority, 40'h00_0000_0200);
    @(posedge clock);
    s_axi_awaddr <= PRIO_LINES_24_27;
    s_axi_wdata <= 32'h00c0_0000;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(negedge clock); while (!(s_axi_awready && s_axi_wready));
    @(posedge clock);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    repeat (4) @(negedge clock);
    chk(40'(s_axi_bvalid), 40'h00_0000_0001);
    chk(40'(s_axi_bresp), 40'(RESP_OKAY));
    @(posedge clock);
    s_axi_bready <= 1'b1;
    @(posedge clock);
    s_axi_bready <= 1'b0;
    @(negedge clock);
    chk(40'(s_axi_bvalid), 40'h00_0000_0000);
    @(posedge clock);
    s_axi_araddr <= PRIO_LINES_24_27;
    s_axi_arvalid <= 1'b1;
    do @(negedge clock); while (!s_axi_arready);
    @(posedge clock);
    s_axi_arvalid <= 1'b0;
    repeat (3) @(negedge clock);
    chk(40'(s_axi_rvalid), 40'h00_0000_0001);
    chk(40'(s_axi_rdata), 40'h00_00c0_0000);
    @(posedge clock);
    s_axi_rready <= 1'b1;
    @(posedge clock);
    s_axi_rready <= 1'b0;
    @(negedge clock);
    chk(40'(s_axi_rvalid), 40'h00_0000_0000);
    chk(line_priority, 40'h00_3000_0200);
    $display("stall test done");
  endtask : t_stall
  // Verdict and end of run
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize
  // Watchdog
  initial begin
    repeat (5000) @(posedge clock);
    error_cnt++;
    summarize();
  end
  // Main sequence
  initial begin
    {clock, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_awprot, s_axi_arprot, s_axi_wdata, s_axi_wstrb} = '0;
    reset = 1'b1;
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    t_fields();
    t_edges();
    t_stall();
    summarize();
  end
endmodule : testbench
bind irq_prio_regs irq_prio_asserts irq_prio_asserts_i (.*);
`default_nettype wire
